// ==== testbench/jtag_host_model.sv ====
/*
 * Behavioural external JTAG controller for the test access port.
 * Assumes core_clk is the bench clock; pins change at its falling edge.
 */
`timescale 1ns/1ps

module jtag_host_model (
    // Bench clock
    input wire logic core_clk,
    // Pins toward the port
    output logic tck,
    output logic tms,
    output logic tms_driven,
    output logic tdi,
    output logic tdi_driven,
    output logic test_reset_n,
    output logic tap_select_pin,
    output logic aux_tdo,
    // Pin from the port
    input wire logic tdo
);
    // =========================================================
    // Idle levels
    // =========================================================
    initial begin
        tck = 1'b0;              // Clock stands still outside frames
        tms = 1'b1;
        tms_driven = 1'b1;
        tdi = 1'b1;
        tdi_driven = 1'b1;
        test_reset_n = 1'b0;     // Unused port held in reset
        tap_select_pin = 1'b1;   // Fabric TAP by default
        aux_tdo = 1'b0;
    end

    // =========================================================
    // Link tasks
    // =========================================================
    // One 80 ns TCK period; tdo taken just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge core_clk);
        tms = tms_driven ? m : ~tms;   // Released line toggles
        tdi = tdi_driven ? d : ~tdi;
        repeat (7) @(negedge core_clk);
        o = tdo;
        tck = 1'b1;
        repeat (8) @(negedge core_clk);
        tck = 1'b0;
    endtask

    // Idle to Shift-IR or Shift-DR
    task automatic enter_shift(input logic ir);
        logic o;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Shift n bits LSB first, update, back to idle
    task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
        logic o;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        repeat (8) @(negedge core_clk);  // Let the strobe land
    endtask

    // Five ones reach Test-Logic-Reset, then idle
    task automatic to_idle();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Side pins, changed by the bench between frames or, for test reset, mid-shift
    task automatic set_reset(input logic v);
        test_reset_n = v;
    endtask

    task automatic set_select(input logic v);
        tap_select_pin = v;
    endtask

    task automatic set_aux(input logic v);
        aux_tdo = v;
    endtask

    // Low lets the pull-up decide the level
    task automatic set_drive(input logic tms_drv, input logic tdi_drv);
        tms_driven = tms_drv;
        tdi_driven = tdi_drv;
    endtask
endmodule

// ==== testbench/tb_jtag_slave_tap_port.sv ====
/*
 * Self-checking bench for the JTAG slave test access port.
 * Assumes jtag_host_model drives every JTAG pin of the port.
 */
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end

module tb_jtag_slave_tap_port
    import jtag_tap_pkg::*;
;
    // =========================================================
    // Signals
    // =========================================================
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic tck, tms, tms_driven, tdi, tdi_driven, test_reset_n, tap_select_pin, aux_tdo;
    logic tdo, tdo_oe_n, aux_selected, scan_reset, swd_reset;
    command_t command;
    data_xfer_t data_to_ctrl;
    logic [DATA_WIDTH-1:0] data_from_ctrl = '0;
    logic [127:0] got;
    logic [7:0] last_code;
    logic [127:0] last_data;
    int failures = 0;
    int n_tests = 0;
    int n_cmd = 0;
    int n_dat = 0;

    // 200 MHz core clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    jtag_host_model m (.core_clk(core_clk), .tck(tck), .tms(tms), .tms_driven(tms_driven),
        .tdi(tdi), .tdi_driven(tdi_driven), .test_reset_n(test_reset_n),
        .tap_select_pin(tap_select_pin), .aux_tdo(aux_tdo), .tdo(tdo));

    jtag_slave_tap_port DUT (.core_clk(core_clk), .reset(reset), .tck(tck), .tms(tms),
        .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven),
        .test_reset_n(test_reset_n), .tap_select_pin(tap_select_pin), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .aux_tdo(aux_tdo), .aux_selected(aux_selected),
        .scan_reset(scan_reset), .serial_wire_debug_port_reset(swd_reset),
        .command(command), .data_to_ctrl(data_to_ctrl), .data_from_ctrl(data_from_ctrl));

    // Strobe counters and captured payloads
    always @(posedge core_clk) begin
        if (command.valid === 1'b1) begin
            n_cmd++;
            last_code = command.code;
        end
        if (data_to_ctrl.valid === 1'b1) begin
            n_dat++;
            last_data = data_to_ctrl.data;
        end
    end

    // =========================================================
    // Scenarios
    // =========================================================
    // Held test reset, then release
    task automatic reset_checks();
        `CHECK("swd_reset", 1'b1, swd_reset)
        `CHECK("scan_reset", 1'b1, scan_reset)
        m.set_reset(1'b1);
        repeat (16) @(negedge core_clk);
        `CHECK("swd_reset", 1'b0, swd_reset)
        `CHECK("tdo_oe_n", 1'b1, tdo_oe_n)
    endtask

    // Eight and ten bit instruction loads
    task automatic ir_load();
        int c0;
        c0 = n_cmd;
        m.to_idle();
        `CHECK("scan_reset", 1'b0, scan_reset)
        m.enter_shift(1'b1);
        m.shift(8, 128'hA5, got);
        `CHECK("ir capture", IR_CAPTURE, got[7:0])
        `CHECK("code", 8'hA5, last_code)
        m.enter_shift(1'b1);
        m.shift(10, 128'h0F2, got);
        `CHECK("ir spill", 2'b10, got[9:8])
        `CHECK("code", 8'h3C, last_code)
        `CHECK("pulses", c0 + 2, n_cmd)
        `CHECK("tdo_oe_n", 1'b1, tdo_oe_n)
    endtask

    // Full 128-bit buffer exchange
    task automatic dr_xfer();
        int d0;
        d0 = n_dat;
        data_from_ctrl = {4{32'hC3A51E0F}};
        m.enter_shift(1'b0);
        m.shift(128, {4{32'h5A0F96E1}}, got);
        `CHECK("dr out", {4{32'hC3A51E0F}}, got)
        `CHECK("dr in", {4{32'h5A0F96E1}}, last_data)
        `CHECK("pulses", d0 + 1, n_dat)
    endtask

    // Bypass bit and no buffer strobe
    task automatic bypass();
        int d0;
        d0 = n_dat;
        m.enter_shift(1'b1);
        m.shift(8, IR_BYPASS, got);
        m.enter_shift(1'b0);
        m.shift(4, 128'hB, got);
        `CHECK("bypass", 4'h6, got[3:0])
        `CHECK("pulses", d0, n_dat)
    endtask

    // Released TDI and TMS read high
    task automatic pull_ups();
        m.set_drive(1'b1, 1'b0);
        m.enter_shift(1'b1);
        m.shift(8, 128'h00, got);
        m.set_drive(1'b1, 1'b1);
        `CHECK("code", 8'hFF, last_code)
        m.set_drive(1'b0, 1'b1);
        m.enter_shift(1'b0);
        repeat (5) m.step(1'b0, 1'b0, got[0]);
        m.set_drive(1'b1, 1'b1);
        `CHECK("scan_reset", 1'b1, scan_reset)
        m.to_idle();
    endtask

    // Secondary TAP passthrough
    task automatic select_aux();
        m.set_select(1'b0);
        for (int i = 0; i < 2; i++) begin
            m.set_aux(i[0]);
            repeat (6) @(negedge core_clk);
            `CHECK("tdo", i[0], tdo)
            `CHECK("tdo_oe_n", 1'b0, tdo_oe_n)
            `CHECK("aux_selected", 1'b1, aux_selected)
        end
        `CHECK("scan_reset", 1'b1, scan_reset)
        m.set_select(1'b1);
        repeat (6) @(negedge core_clk);
        `CHECK("aux_selected", 1'b0, aux_selected)
        `CHECK("tdo_oe_n", 1'b1, tdo_oe_n)
        m.to_idle();
    endtask

    // Test reset in mid-shift, seen before any clock edge
    task automatic reset_mid();
        int c0;
        c0 = n_cmd;
        m.enter_shift(1'b1);
        repeat (3) m.step(1'b0, 1'b1, got[0]);
        @(negedge core_clk);
        m.set_reset(1'b0);
        #1;
        `CHECK("scan_reset", 1'b1, scan_reset)
        `CHECK("swd_reset", 1'b1, swd_reset)
        `CHECK("tdo_oe_n", 1'b1, tdo_oe_n)
        @(negedge core_clk);
        m.set_reset(1'b1);
        repeat (16) @(negedge core_clk);
        `CHECK("pulses", c0, n_cmd)
    endtask

    // =========================================================
    // Verdict
    // =========================================================
    task automatic close_out();
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        reset_checks();
        ir_load();
        dr_xfer();
        bypass();
        pull_ups();
        select_aux();
        reset_mid();
        close_out();
    end
endmodule

// ==== verilog/jtag_slave_tap_port.sv ====
/*
 * JTAG slave test access port: TAP controller, 8-bit instruction register,
 * command register and 128-bit data buffer toward the system controller.
 * Assumes all JTAG pins are asynchronous to core_clk and that TCK runs far
 * slower than core_clk, so its edges are found by oversampling.
 */
`timescale 1ns/1ps

// Functional notes
// [RULE_01] Behaves as 1532-capable 1149.1 JTAG slave
// [RULE_02] Instruction to command register; data via buffer
// [RULE_03] Instruction register is eight bits long
// [RULE_04] Select high: fabric TAP; low: secondary TAP
// [RULE_05] Test reset low resets TAP asynchronously
// [RULE_06] Test reset also resets debug port
// [RULE_07] Undriven TDI and TMS read high
// [RULE_08] Unused port: system holds test reset low
// [RULE_09] Sixteen-state TAP; sample rising, drive falling
module jtag_slave_tap_port
    import jtag_tap_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // JTAG pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_driven,
    input wire logic tdi,
    input wire logic tdi_driven,
    input wire logic test_reset_n,
    input wire logic tap_select_pin,
    output logic tdo,
    output logic tdo_oe_n,
    // Secondary TAP
    input wire logic aux_tdo,
    output logic aux_selected,
    // Resets out
    output logic scan_reset,
    output logic serial_wire_debug_port_reset,
    // System controller side
    output command_t command,
    output data_xfer_t data_to_ctrl,
    input wire logic [DATA_WIDTH-1:0] data_from_ctrl
);

    // =========================================================
    // Declarations
    // =========================================================
    logic [SYNC_WIDTH-1:0] sync1;          // First synchroniser stage
    logic [SYNC_WIDTH-1:0] sync2;          // Second synchroniser stage
    logic tck_prev;                        // Delayed TCK for edge finding
    logic tck_rise;                        // TCK rising edge seen
    logic tck_fall;                        // TCK falling edge seen
    logic tms_eff;                         // TMS after pull-up
    logic tdi_eff;                         // TDI after pull-up
    logic fabric_sel;                      // Fabric TAP selected
    tap_state_t state;                     // TAP controller state
    logic [IR_WIDTH-1:0] ir;               // Active instruction
    logic [IR_WIDTH-1:0] ir_shift;         // Instruction shift stage
    logic [DATA_WIDTH-1:0] dbuf;           // Data buffer shift stage
    logic bypass_bit;                      // Bypass register
    logic is_bypass;                       // Active instruction is bypass

    // =========================================================
    // TAP next-state function
    // =========================================================
    function automatic tap_state_t next_tap(input tap_state_t cur, input logic m);
        case (cur)
            S_TLR: next_tap = m ? S_TLR : S_RTI;
            S_RTI: next_tap = m ? S_SEL_DR : S_RTI;
            S_SEL_DR: next_tap = m ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: next_tap = m ? S_EX1_DR : S_SH_DR;
            S_SH_DR: next_tap = m ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: next_tap = m ? S_UP_DR : S_PA_DR;
            S_PA_DR: next_tap = m ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: next_tap = m ? S_UP_DR : S_SH_DR;
            S_UP_DR: next_tap = m ? S_SEL_DR : S_RTI;
            S_SEL_IR: next_tap = m ? S_TLR : S_CAP_IR;
            S_CAP_IR: next_tap = m ? S_EX1_IR : S_SH_IR;
            S_SH_IR: next_tap = m ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: next_tap = m ? S_UP_IR : S_PA_IR;
            S_PA_IR: next_tap = m ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: next_tap = m ? S_UP_IR : S_SH_IR;
            S_UP_IR: next_tap = m ? S_SEL_DR : S_RTI;
            default: next_tap = S_TLR;
        endcase
    endfunction

    // =========================================================
    // Pin synchroniser and edge finding
    // =========================================================
    // Two flops per pin; only the second stage feeds logic
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {aux_tdo, tap_select_pin, tdi_driven, tdi, tms_driven, tms, tck};
            sync2 <= sync1;
        end
    end

    // Previous TCK level
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= sync2[SYNC_TCK];
        end
    end

    assign tck_rise = sync2[SYNC_TCK] & ~tck_prev;   // [RULE_09]
    assign tck_fall = ~sync2[SYNC_TCK] & tck_prev;   // [RULE_09]
    // Weak pull-ups on undriven inputs
    assign tms_eff = sync2[SYNC_TMS_DRV] ? sync2[SYNC_TMS] : 1'b1;   // [RULE_07]
    assign tdi_eff = sync2[SYNC_TDI_DRV] ? sync2[SYNC_TDI] : 1'b1;   // [RULE_07]
    assign fabric_sel = sync2[SYNC_SEL];   // [RULE_04]
    assign is_bypass = (ir == IR_BYPASS);
    assign aux_selected = ~fabric_sel;   // [RULE_04]

    // =========================================================
    // TAP controller state
    // =========================================================
    // Test reset acts without any clock edge from TCK
    always_ff @(posedge core_clk or negedge test_reset_n) begin
        if (!test_reset_n) begin
            state <= S_TLR;   // [RULE_05]
        end else if (reset || !fabric_sel) begin
            state <= S_TLR;   // [RULE_04]
        end else if (tck_rise) begin
            state <= next_tap(state, tms_eff);   // [RULE_09] [RULE_01]
        end
    end

    // Reset outputs toward boundary scan and debug port
    always_ff @(posedge core_clk or negedge test_reset_n) begin
        if (!test_reset_n) begin
            scan_reset <= 1'b1;   // [RULE_05]
            serial_wire_debug_port_reset <= 1'b1;   // [RULE_06]
        end else if (reset) begin
            scan_reset <= 1'b1;
            serial_wire_debug_port_reset <= 1'b0;
        end else begin
            scan_reset <= (state == S_TLR);
            serial_wire_debug_port_reset <= 1'b0;
        end
    end

    // =========================================================
    // Instruction register and command strobe
    // =========================================================
    // Capture and shift on rising TCK, update on falling TCK
    always_ff @(posedge core_clk or negedge test_reset_n) begin
        if (!test_reset_n) begin
            ir <= IR_BYPASS;
            ir_shift <= IR_CAPTURE;
            command <= '0;
        end else if (reset || state == S_TLR) begin
            ir <= IR_BYPASS;
            ir_shift <= IR_CAPTURE;
            command <= '0;
        end else begin
            command.valid <= 1'b0;
            if (tck_rise && state == S_CAP_IR) begin
                ir_shift <= IR_CAPTURE;   // [RULE_03]
            end else if (tck_rise && state == S_SH_IR) begin
                ir_shift <= {tdi_eff, ir_shift[IR_WIDTH-1:1]};   // [RULE_03]
            end
            if (tck_fall && state == S_UP_IR) begin
                ir <= ir_shift;
                command.valid <= 1'b1;   // [RULE_02]
                command.code <= ir_shift;   // [RULE_02]
            end
        end
    end

    // =========================================================
    // Data buffer, bypass and data strobe
    // =========================================================
    always_ff @(posedge core_clk or negedge test_reset_n) begin
        if (!test_reset_n) begin
            dbuf <= '0;
            bypass_bit <= 1'b0;
            data_to_ctrl <= '0;
        end else if (reset) begin
            dbuf <= '0;
            bypass_bit <= 1'b0;
            data_to_ctrl <= '0;
        end else begin
            data_to_ctrl.valid <= 1'b0;
            if (tck_rise && state == S_CAP_DR) begin
                bypass_bit <= 1'b0;
                if (!is_bypass) begin
                    dbuf <= data_from_ctrl;   // [RULE_02]
                end
            end else if (tck_rise && state == S_SH_DR) begin
                if (is_bypass) begin
                    bypass_bit <= tdi_eff;
                end else begin
                    dbuf <= {tdi_eff, dbuf[DATA_WIDTH-1:1]};   // [RULE_02]
                end
            end
            if (tck_fall && state == S_UP_DR && !is_bypass) begin
                data_to_ctrl.valid <= 1'b1;   // [RULE_02]
                data_to_ctrl.data <= dbuf;   // [RULE_02]
            end
        end
    end

    // =========================================================
    // TDO driver
    // =========================================================
    // Fabric TAP drives only in shift states, on falling TCK
    always_ff @(posedge core_clk or negedge test_reset_n) begin
        if (!test_reset_n) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (reset) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (!fabric_sel) begin
            tdo <= sync2[SYNC_AUX_TDO];   // [RULE_04]
            tdo_oe_n <= 1'b0;
        end else if (state == S_TLR) begin
            // Parked TAP releases TDO, also once the secondary TAP lets go
            tdo_oe_n <= 1'b1;   // [RULE_04]
        end else if (tck_fall) begin
            if (state == S_SH_IR) begin
                tdo <= ir_shift[0];   // [RULE_09]
                tdo_oe_n <= 1'b0;
            end else if (state == S_SH_DR) begin
                tdo <= is_bypass ? bypass_bit : dbuf[0];   // [RULE_09]
                tdo_oe_n <= 1'b0;
            end else begin
                tdo_oe_n <= 1'b1;
            end
        end
    end

    // =========================================================
    // Assertions
    // =========================================================
    a_tap_reset_hold: assert property (  // [RULE_05]
        @(posedge core_clk) disable iff (reset) !test_reset_n |-> state == S_TLR)
        else $error("TAP not in reset while test reset low");

    a_debug_reset: assert property (  // [RULE_06]
        @(posedge core_clk) disable iff (reset)
        !test_reset_n |-> serial_wire_debug_port_reset && scan_reset)
        else $error("Debug port not reset with test reset");

    a_aux_select: assert property (  // [RULE_04]
        @(posedge core_clk) disable iff (reset || !test_reset_n)
        !fabric_sel |-> aux_selected ##1 (state == S_TLR && !tdo_oe_n))
        else $error("Secondary TAP select not honoured");

    a_state_onehot: assert property (  // [RULE_09]
        @(posedge core_clk) disable iff (reset) $onehot(state))
        else $error("TAP state not one-hot");

    a_move_on_rise: assert property (  // [RULE_09]
        @(posedge core_clk) disable iff (reset || !test_reset_n)
        $changed(state) && $past(fabric_sel) && fabric_sel |-> $past(tck_rise))
        else $error("TAP state moved without TCK rise");

    a_pullup_tms: assert property (  // [RULE_07]
        @(posedge core_clk) disable iff (reset || !test_reset_n || !fabric_sel)
        tck_rise && !sync2[SYNC_TMS_DRV] && state == S_RTI |=> state == S_SEL_DR)
        else $error("Undriven TMS not read as high");

    a_ir_capture: assert property (  // [RULE_03]
        @(posedge core_clk) disable iff (reset || !test_reset_n || !fabric_sel)
        tck_rise && state == S_CAP_IR |=> ir_shift == IR_CAPTURE)
        else $error("Capture-IR pattern wrong");

    a_cmd_strobe: assert property (  // [RULE_02]
        @(posedge core_clk) disable iff (reset || !test_reset_n)
        command.valid |-> $past(state) == S_UP_IR && command.code == ir ##1 !command.valid)
        else $error("Command strobe misplaced");

    a_data_strobe: assert property (  // [RULE_02]
        @(posedge core_clk) disable iff (reset || !test_reset_n)
        data_to_ctrl.valid |-> $past(state) == S_UP_DR && !is_bypass ##1 !data_to_ctrl.valid)
        else $error("Data strobe misplaced");

    a_tdo_shift: assert property (  // [RULE_09]
        @(posedge core_clk) disable iff (reset || !test_reset_n || !fabric_sel)
        $fell(tdo_oe_n) |-> $past(tck_fall) && ($past(state) == S_SH_DR || $past(state) == S_SH_IR))
        else $error("TDO enabled outside shift");

endmodule

// ==== verilog/jtag_tap_pkg.sv ====
/*
 * Shared constants and types for the JTAG slave test access port.
 * Assumes a single core clock domain that oversamples every JTAG pin except test_reset_n, which acts asynchronously.
 */
package jtag_tap_pkg;

    // =========================================================
    // Widths
    // =========================================================
    localparam int IR_WIDTH = 8;          // Instruction length
    localparam int DATA_WIDTH = 128;      // Data buffer length
    localparam int SYNC_WIDTH = 7;        // Pins passed through the synchroniser

    // =========================================================
    // Instruction codes and capture patterns
    // =========================================================
    localparam logic [IR_WIDTH-1:0] IR_BYPASS = 8'hFF;    // All-ones selects bypass
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 8'h01;   // Loaded on Capture-IR

    // =========================================================
    // Synchroniser bit positions
    // =========================================================
    localparam int SYNC_TCK = 0;
    localparam int SYNC_TMS = 1;
    localparam int SYNC_TMS_DRV = 2;
    localparam int SYNC_TDI = 3;
    localparam int SYNC_TDI_DRV = 4;
    localparam int SYNC_SEL = 5;
    localparam int SYNC_AUX_TDO = 6;

    // =========================================================
    // TAP controller states, one-hot
    // =========================================================
    typedef enum logic [15:0] {
        S_TLR = 16'h0001,
        S_RTI = 16'h0002,
        S_SEL_DR = 16'h0004,
        S_CAP_DR = 16'h0008,
        S_SH_DR = 16'h0010,
        S_EX1_DR = 16'h0020,
        S_PA_DR = 16'h0040,
        S_EX2_DR = 16'h0080,
        S_UP_DR = 16'h0100,
        S_SEL_IR = 16'h0200,
        S_CAP_IR = 16'h0400,
        S_SH_IR = 16'h0800,
        S_EX1_IR = 16'h1000,
        S_PA_IR = 16'h2000,
        S_EX2_IR = 16'h4000,
        S_UP_IR = 16'h8000
    } tap_state_t;

    // =========================================================
    // Carriers toward the system controller
    // =========================================================
    typedef struct packed {
        logic valid;                      // One-cycle strobe
        logic [IR_WIDTH-1:0] code;        // Instruction to execute
    } command_t;

    typedef struct packed {
        logic valid;                      // One-cycle strobe
        logic [DATA_WIDTH-1:0] data;      // Buffer contents
    } data_xfer_t;

endpackage
